//--- shared/scwp_pkg.sv
// constants for the control write port: word layout, status layout, queue
package scwp_pkg;
    localparam int          WORD_W        = 32;
    localparam int          CNT_W         = 6;
    localparam int          CMD_MSB       = 31;
    localparam int          CMD_LSB       = 30;
    localparam int          ADDR_W        = 30;
    localparam int          BANK_SHIFT    = 20;
    localparam int          BANK_W        = ADDR_W - BANK_SHIFT;
    localparam logic [1:0]  CMD_WRITE     = 2'h0;
    localparam logic [29:0] POLL_ADDR     = 30'h0000000;
    localparam logic [5:0]  LAST_BIT      = 6'h1f;
    localparam int          ST_PHASE_BIT  = 31;
    localparam int          ST_FILL_LSB   = 24;
    localparam int          FILL_W        = 7;
    localparam int          ST_LINK_LSB   = 16;
    localparam int          ST_BOARD_LSB  = 4;
    localparam int          ST_VER_LSB    = 0;
    localparam logic        PHASE_ADDR    = 1'b0;
    localparam logic        PHASE_DATA    = 1'b1;
    localparam int          QUEUE_DEPTH   = 16;
    localparam logic [3:0]  BOARD_ID_DEF  = 4'h1;
    localparam logic [3:0]  VERSION_DEF   = 4'h1;
endpackage

//--- verilog/scwp_mem.sv
// small queue memory with registered read data
`timescale 1ns/10ps
module scwp_mem #(
    parameter int WIDTH = 62,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             mclk_in,
    input  wire logic             wr_en_in,
    input  wire logic [AW-1:0]    wr_addr_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             rd_en_in,
    input  wire logic [AW-1:0]    rd_addr_in,
    output logic      [WIDTH-1:0] rd_data_out
);
    logic [WIDTH-1:0] mem_r [DEPTH];

    generate
        if (DEPTH != (1 << AW)) begin : g_bad
            $error("scwp_mem depth must equal 2**AW");
        end
    endgenerate

    // no reset on the array: contents are only read after being written
    always_ff @(posedge mclk_in) begin
        if (wr_en_in) begin
            mem_r[wr_addr_in] <= wr_data_in;
        end
        if (rd_en_in) begin
            rd_data_out <= mem_r[rd_addr_in];
        end
    end
endmodule

//--- verilog/scwp_top.sv
// spi slave control write port with command queue and status word
`timescale 1ns/10ps
//
// Function
// - all shifts on the port are framed as 32-bit words.
// - a register write is an address word followed by a data word.
// - first word carries 2-bit command on top and 30-bit byte address.
// - second word is the 32-bit value for the preceding address.
// - status word shifted out in every word, twice per write.
// - command 00 is write; other codes reserved and not queued.
// - address space split into 1 MByte banks by upper address bits.
// - byte addresses, but only whole 32-bit word writes exist.
// - one read-only status word; addressed registers are write-only.
// - received writes are queued, except to address 0 or when full, and handed out in arrival order.
// - status top bit 0 in address phase, 1 in data phase.
// - status field shows commands waiting; zero means all processed.
// - status bits 7-4 board identifier, bits 3-0 version.
module scwp_top
    import scwp_pkg::*;
#(
    parameter int         DEPTH    = QUEUE_DEPTH,
    parameter logic [3:0] BOARD_ID = BOARD_ID_DEF, // arbitrary value
    parameter logic [3:0] VERSION  = VERSION_DEF   // arbitrary value
) (
    input  wire logic                mclk_in,
    input  wire logic                srst_in,
    input  wire logic                sclk_in,
    input  wire logic                cs_n_in,
    input  wire logic                mosi_in,
    output logic                     miso_out,
    output logic                     miso_oe_n_out,
    input  wire logic [7:0]          link_status_in,
    input  wire logic                tx_empty_in,
    input  wire logic                tx_error_in,
    input  wire logic                rx_full_in,
    input  wire logic                rx_empty_in,
    input  wire logic                rx_error_in,
    output logic                     cmd_valid_out,
    input  wire logic                cmd_ready_in,
    output logic [ADDR_W-1:0]        cmd_addr_out,
    output logic [BANK_W-1:0]        cmd_bank_out,
    output logic [BANK_SHIFT-1:0]    cmd_offset_out,
    output logic [WORD_W-1:0]        cmd_data_out
);
    localparam int AW  = $clog2(DEPTH);
    localparam int QW  = ADDR_W + WORD_W;
    localparam logic [FILL_W-1:0] DEPTH_C = FILL_W'(DEPTH);

    generate
        if (DEPTH < 2 || DEPTH > 64 || DEPTH != (1 << AW)) begin : g_bad
            $error("scwp_top depth must be a power of two from 2 to 64");
        end
    endgenerate

    typedef struct packed {
        logic                sclk_m;
        logic                sclk_s;
        logic                sclk_p;
        logic                cs_m;
        logic                cs_s;
        logic                cs_p;
        logic                mosi_m;
        logic                mosi_s;
        logic [CNT_W-1:0]    bit_cnt;
        logic [WORD_W-1:0]   rx_sh;
        logic [WORD_W-1:0]   tx_sh;
        logic                hold;
        logic                phase;
        logic [1:0]          cmd;
        logic [ADDR_W-1:0]   addr;
        logic [AW-1:0]       wptr;
        logic [AW-1:0]       rptr;
        logic [FILL_W-1:0]   count;
        logic                rd_pend;
        logic                out_valid;
        logic [ADDR_W-1:0]   out_addr;
        logic [WORD_W-1:0]   out_data;
        logic                miso;
        logic                miso_oe_n;
    } scwp_state_t;

    scwp_state_t       s_r;
    scwp_state_t       s_nxt;
    logic              rise;
    logic              fall;
    logic              cs_act;
    logic              cs_start;
    logic              word_done;
    logic              push;
    logic              issue;
    logic [WORD_W-1:0] rx_word;
    logic [FILL_W-1:0] fill;
    logic [QW-1:0]     rd_data;

    function automatic logic [WORD_W-1:0] mk_status(
        input logic              ph,
        input logic [FILL_W-1:0] fl
    );
        logic [WORD_W-1:0] w;
        w                                   = '0;
        w[ST_PHASE_BIT]                     = ph;
        w[ST_FILL_LSB +: FILL_W]            = fl;
        w[ST_LINK_LSB +: 8]                 = link_status_in;
        w[13]                               = tx_empty_in;
        w[12]                               = tx_error_in;
        w[10]                               = rx_full_in;
        w[9]                                = rx_empty_in;
        w[8]                                = rx_error_in;
        w[ST_BOARD_LSB +: 4]                = BOARD_ID;
        w[ST_VER_LSB +: 4]                  = VERSION;
        return w;
    endfunction

    function automatic logic [BANK_W-1:0] bank_of(
        input logic [ADDR_W-1:0] a
    );
        return a[ADDR_W-1:BANK_SHIFT];
    endfunction

    scwp_mem #(
        .WIDTH (QW),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_queue (
        .mclk_in     (mclk_in),
        .wr_en_in    (push),
        .wr_addr_in  (s_r.wptr),
        .wr_data_in  ({s_r.addr, rx_word}),
        .rd_en_in    (issue),
        .rd_addr_in  (s_r.rptr),
        .rd_data_out (rd_data)
    );

    always_comb begin
        s_nxt     = s_r;
        s_nxt.sclk_m = sclk_in;
        s_nxt.sclk_s = s_r.sclk_m;
        s_nxt.sclk_p = s_r.sclk_s;
        s_nxt.cs_m   = cs_n_in;
        s_nxt.cs_s   = s_r.cs_m;
        s_nxt.cs_p   = s_r.cs_s;
        s_nxt.mosi_m = mosi_in;
        s_nxt.mosi_s = s_r.mosi_m;
        // mode 0: sample on rising sclk, change output on falling sclk
        rise      = s_r.sclk_s & ~s_r.sclk_p;
        fall      = ~s_r.sclk_s & s_r.sclk_p;
        cs_act    = ~s_r.cs_s;
        cs_start  = ~s_r.cs_s & s_r.cs_p;
        word_done = cs_act & rise & (s_r.bit_cnt == LAST_BIT);
        rx_word   = {s_r.rx_sh[WORD_W-2:0], s_r.mosi_s};
        fill      = s_r.count + FILL_W'(s_r.rd_pend)
                    + FILL_W'(s_r.out_valid);
        push      = 1'b0;
        issue     = ~s_r.rd_pend & ~s_r.out_valid & (s_r.count != '0);
        s_nxt.miso_oe_n = ~cs_act;
        if (!cs_act) begin
            // a partial word is dropped, the phase is kept
            s_nxt.bit_cnt = '0;
            s_nxt.hold    = 1'b0;
        end
        if (cs_start) begin
            s_nxt.tx_sh = mk_status(s_r.phase, fill);
            s_nxt.hold  = 1'b0;
        end
        if (cs_act && rise) begin
            s_nxt.rx_sh   = rx_word;
            s_nxt.bit_cnt = s_r.bit_cnt + CNT_W'(1);
        end
        if (word_done) begin
            s_nxt.bit_cnt = '0;
            if (s_r.phase == PHASE_ADDR) begin
                s_nxt.cmd   = rx_word[CMD_MSB:CMD_LSB];
                s_nxt.addr  = rx_word[ADDR_W-1:0];
                s_nxt.phase = PHASE_DATA;
            end else begin
                // poll address and reserved codes refresh status only
                push = (s_r.cmd == CMD_WRITE) && (s_r.addr != POLL_ADDR)
                       && (s_r.count < DEPTH_C);
                s_nxt.phase = PHASE_ADDR;
            end
            // next word carries a fresh snapshot of the status
            s_nxt.tx_sh = mk_status(s_nxt.phase, fill);
            s_nxt.hold  = 1'b1;
        end else if (cs_act && fall) begin
            if (s_r.hold) begin
                s_nxt.hold = 1'b0;
            end else begin
                s_nxt.tx_sh = {s_r.tx_sh[WORD_W-2:0], 1'b0};
            end
        end
        s_nxt.miso = s_nxt.tx_sh[WORD_W-1];
        if (push) begin
            s_nxt.wptr = s_r.wptr + AW'(1);
        end
        if (issue) begin
            s_nxt.rptr    = s_r.rptr + AW'(1);
            s_nxt.rd_pend = 1'b1;
        end
        if (s_r.rd_pend) begin
            s_nxt.rd_pend   = 1'b0;
            s_nxt.out_valid = 1'b1;
            s_nxt.out_addr  = rd_data[QW-1:WORD_W];
            s_nxt.out_data  = rd_data[WORD_W-1:0];
        end
        if (s_r.out_valid && cmd_ready_in) begin
            s_nxt.out_valid = 1'b0;
        end
        s_nxt.count = s_r.count + FILL_W'(push) - FILL_W'(issue);
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            s_r           <= '0;
            s_r.sclk_m    <= 1'b0;
            s_r.cs_m      <= 1'b1;
            s_r.cs_s      <= 1'b1;
            s_r.cs_p      <= 1'b1;
            s_r.miso_oe_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign miso_out       = s_r.miso;
    assign miso_oe_n_out  = s_r.miso_oe_n;
    assign cmd_valid_out  = s_r.out_valid;
    assign cmd_addr_out   = s_r.out_addr;
    assign cmd_bank_out   = bank_of(s_r.out_addr);
    assign cmd_offset_out = s_r.out_addr[BANK_SHIFT-1:0];
    assign cmd_data_out   = s_r.out_data;

    a_word_length: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        word_done |=> s_r.bit_cnt == '0 && s_r.hold)
        else $error("word ended at wrong bit count");

    a_pair_return: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        (word_done && s_r.phase == PHASE_DATA) |=> s_r.phase == PHASE_ADDR)
        else $error("phase did not return to address after data word");

    a_addr_no_push: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        push |-> word_done && s_r.phase == PHASE_DATA)
        else $error("queue written outside a data word");

    a_reserved_cmd: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        (word_done && s_r.phase == PHASE_DATA && s_r.cmd != CMD_WRITE)
        |-> !push)
        else $error("reserved command was queued");

    a_fill_field: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        cs_start |=> s_r.tx_sh[30:24] == $past(fill))
        else $error("fill field differs from queued count");

    a_ident_bits: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        word_done |=> s_r.tx_sh[7:0] == {BOARD_ID, VERSION})
        else $error("identity bits wrong in status snapshot");

    a_phase_bit: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        word_done |=> s_r.tx_sh[31] == s_r.phase && s_r.hold)
        else $error("status top bit does not match phase");

    a_pop_latency: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        issue |=> s_r.rd_pend ##1 s_r.out_valid)
        else $error("queued command not presented two cycles after read");

    a_out_hold: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        (s_r.out_valid && !cmd_ready_in) |=>
        s_r.out_valid && $stable(s_r.out_data) && $stable(s_r.out_addr))
        else $error("command output changed while stalled");

    a_snap_stable: assert property (
        @(posedge mclk_in) disable iff (srst_in)
        (cs_act && !rise && !fall && !cs_start) |=> $stable(s_r.tx_sh))
        else $error("status shifter moved without an sclk edge");
endmodule

//--- verif/scwp_host.sv
// host adapter model: spi master that writes over the control port
`timescale 1ns/10ps
module scwp_host (
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      mosi_out,
    input  wire logic miso_in
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    // mode 0 word; fewer than 32 bits aborts the word by raising cs_n
    task automatic xfer(input logic [31:0] w, input int nbits,
                        input bit keep, output logic [31:0] st);
        st = 32'h0;
        if (cs_n_out) begin
            // step off the system clock edge so no pin moves with it
            #2 cs_n_out = 1'b0;
            #80;
        end
        for (int i = 31; i > 31 - nbits; i--) begin
            mosi_out = w[i];
            #62.5 sclk_out = 1'b1;
            st = {st[30:0], miso_in};
            #62.5 sclk_out = 1'b0;
        end
        if (!keep || nbits < 32) begin
            #60 cs_n_out = 1'b1;
            // released line stops showing the last bit
            mosi_out = ~mosi_out;
            #300;
        end
    endtask
    // chip select stays low across the pair, as a real adapter may do
    task automatic write(input logic [1:0] cmd, input logic [29:0] addr,
                         input logic [31:0] data,
                         output logic [31:0] st0, output logic [31:0] st1);
        xfer({cmd, addr}, 32, 1'b1, st0);
        xfer(data, 32, 1'b0, st1);
    endtask
endmodule

//--- verif/tb.sv
// self-checking bench: host model writes, command port drained and compared
`timescale 1ns/10ps
module tb;
    import scwp_pkg::*;
    localparam int DEP = 4;
    logic                  mclk_in = 1'b0;
    logic                  srst_in = 1'b1;
    logic                  sclk, cs_n, mosi, miso, miso_oe_n, miso_line;
    logic [7:0]            link_status = 8'h00;
    logic [4:0]            flags = 5'h00;
    logic                  cmd_valid;
    logic                  cmd_ready = 1'b0;
    logic [ADDR_W-1:0]     c_addr;
    logic [BANK_W-1:0]     c_bank;
    logic [BANK_SHIFT-1:0] c_offset;
    logic [WORD_W-1:0]     c_data;
    logic [31:0]           st;
    int                    failures = 0;
    int                    cmp_count = 0;
    int                    seed = 32'h036c;
    logic [61:0]           expq[$];

    always #5 mclk_in = ~mclk_in;
    // shared line assumed pulled up while the device releases it
    assign miso_line = miso_oe_n ? 1'b1 : miso;

    scwp_top #(.DEPTH(DEP)) u_scwp_top (
        .mclk_in(mclk_in), .srst_in(srst_in), .sclk_in(sclk),
        .cs_n_in(cs_n), .mosi_in(mosi), .miso_out(miso),
        .miso_oe_n_out(miso_oe_n), .link_status_in(link_status),
        .tx_empty_in(flags[4]), .tx_error_in(flags[3]),
        .rx_full_in(flags[2]), .rx_empty_in(flags[1]),
        .rx_error_in(flags[0]), .cmd_valid_out(cmd_valid),
        .cmd_ready_in(cmd_ready), .cmd_addr_out(c_addr),
        .cmd_bank_out(c_bank), .cmd_offset_out(c_offset),
        .cmd_data_out(c_data)
    );
    scwp_host u_scwp_host (
        .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi),
        .miso_in(miso_line)
    );

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %0h expected %0h",
                     $time, got, exp);
        end
    endtask

    function automatic logic [31:0] exp_st(input logic ph);
        return {ph, 7'(expq.size()), link_status, 2'b00, flags[4:3],
                1'b0, flags[2:0], BOARD_ID_DEF, VERSION_DEF};
    endfunction

    task automatic do_write(input logic [1:0] cmd, input logic [29:0] a,
                            input logic [31:0] d);
        logic [31:0] e0, e1, s0, s1;
        @(posedge mclk_in);
        link_status <= 8'($random(seed));
        flags <= 5'($random(seed));
        @(posedge mclk_in);
        e0 = exp_st(PHASE_ADDR);
        e1 = exp_st(PHASE_DATA);
        u_scwp_host.write(cmd, a, d, s0, s1);
        chk(s0, e0);
        chk(s1, e1);
        // the output register holds one command beyond the memory depth
        if (cmd == CMD_WRITE && a != POLL_ADDR && expq.size() < DEP + 1)
            expq.push_back({a, d});
    endtask

    task automatic drain();
        logic [61:0] e;
        @(posedge mclk_in) cmd_ready <= 1'b1;
        for (int i = 0; i < 400; i++) begin
            @(negedge mclk_in);
            if (cmd_valid === 1'b1) begin
                e = expq.size() > 0 ? expq.pop_front() : '1;
                chk({c_addr, c_data}, e);
                chk({c_bank, c_offset}, e[61:32]);
            end
        end
        chk(expq.size(), 0);
        @(posedge mclk_in) cmd_ready <= 1'b0;
    endtask

    task automatic conclude();
        $display("checks %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    function automatic logic [29:0] rnd_addr();
        return {28'($random(seed)) | 28'h1, 2'b00};
    endfunction

    initial begin
        repeat (20) @(posedge mclk_in);
        srst_in <= 1'b0;
        repeat (10) @(posedge mclk_in);
        chk({miso_oe_n, cmd_valid}, 2'b10);
        for (int c = 1; c < 4; c++) begin
            do_write(2'(c), rnd_addr(), 32'($random(seed)));
        end
        do_write(CMD_WRITE, POLL_ADDR, 32'($random(seed)));
        $display("test reserved codes and poll done");
        // more writes than the queue holds; the surplus is dropped
        for (int i = 0; i < DEP + 2; i++) begin
            do_write(CMD_WRITE, rnd_addr(), 32'($random(seed)));
        end
        drain();
        $display("test fill and drain done");
        u_scwp_host.xfer(32'hffffffff, 10, 1'b0, st);
        chk(st[9:0], exp_st(PHASE_ADDR) >> 22);
        do_write(CMD_WRITE, rnd_addr(), 32'($random(seed)));
        drain();
        do_write(CMD_WRITE, POLL_ADDR, 32'h0);
        chk(miso_oe_n, 1'b1);
        $display("test abort and poll done");
        conclude();
    end
endmodule
